// file: hw/mcah_coil_handler.sv
// Coil read and write command handler with Wishbone register port
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module mcah_coil_handler (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_arst_n,
   // Received frame bytes
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_data,
   input wire logic i_rx_end,
   // Reply bytes
   output logic o_tx_valid,
   output logic [7:0] o_tx_data,
   output logic o_tx_last,
   input wire logic i_tx_ready,
   // Drive status groups
   input wire logic [15:0] i_run_status_word,
   input wire logic [15:0] i_run_status_word_two,
   input wire logic [15:0] i_final_run_command_word,
   input wire logic [15:0] i_output_terminal_info_word,
   output logic [15:0] o_run_command_word,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [3:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   mcah_pkg::mcah_regs_t s;
   mcah_pkg::mcah_regs_t next_s;

   function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int k = 0; k < 8; k++) begin
         r = r[0] ? ((r >> 1) ^ mcah_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_upd

   ////////////////////////////////////////////////////////////////////////////
   // Request fields

   logic [7:0] q_fc;
   logic [15:0] q_adr;
   logic [15:0] q_cnt;
   logic [7:0] q_bc;
   logic [15:0] q_wdat;
   logic for_us;
   logic bcast;
   logic [79:0] coils;

   assign q_fc = s.rxb[1];
   assign q_adr = {s.rxb[2], s.rxb[3]};
   assign q_cnt = {s.rxb[4], s.rxb[5]};
   assign q_bc = s.rxb[6];
   assign q_wdat = {s.rxb[8], s.rxb[7]};
   // Station zero never answered
   assign for_us = s.st == mcah_pkg::MCAH_EXEC && s.rxb[0] == s.station
                   && s.rxb[0] != mcah_pkg::BCAST;
   assign bcast = s.st == mcah_pkg::MCAH_EXEC && s.rxb[0] == mcah_pkg::BCAST;

   // Coil image, reserved positions forced low
   assign coils = {i_output_terminal_info_word & ~mcah_pkg::RSV_OUT,
                   i_final_run_command_word & ~mcah_pkg::RSV_FINAL,
                   i_run_status_word_two & ~mcah_pkg::RSV_STAT2,
                   i_run_status_word,
                   s.run_cmd & ~mcah_pkg::RSV_RUN};

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [79:0] sh;
      logic [79:0] msk;
      logic [7:0] sub;
      logic [15:0] nb;
      logic [15:0] wr;
      logic [3:0] rlen;
      sh = '0;
      msk = '0;
      sub = '0;
      nb = '0;
      wr = s.run_cmd;
      rlen = '0;
      next_s = s;
      next_s.ack = 1'b0;

      // Wishbone slave, one wait state, unmapped reads zero
      if (i_wb_cyc && i_wb_stb && !s.ack) begin
         next_s.ack = 1'b1;
         next_s.rdat = '0;
         if (i_wb_adr == mcah_pkg::WB_STATION) begin
            next_s.rdat = {24'h000000, s.station};
            if (i_wb_we && i_wb_sel[0]) begin
               next_s.station = i_wb_dat[7:0];
            end
         end else if (i_wb_adr == mcah_pkg::WB_RUN) begin
            next_s.rdat = {16'h0000, s.run_cmd};
            if (i_wb_we && i_wb_sel[0]) begin
               next_s.run_cmd[7:0] = i_wb_dat[7:0] & ~mcah_pkg::RSV_RUN[7:0];
            end
            if (i_wb_we && i_wb_sel[1]) begin
               next_s.run_cmd[15:8] = i_wb_dat[15:8] & ~mcah_pkg::RSV_RUN[15:8];
            end
         end else if (i_wb_adr == mcah_pkg::WB_SUB) begin
            next_s.rdat = {24'h000000, s.last_sub};
         end
      end

      case (s.st)
         mcah_pkg::MCAH_RX: begin
            if (i_rx_end) begin
               next_s.rxn = '0;
               next_s.rx_ovf = 1'b0;
               next_s.rx_crc = mcah_pkg::CRC_INIT;
               // Bad check or short frame: dropped
               if (s.rx_crc == 16'h0000 && !s.rx_ovf && s.rxn >= mcah_pkg::LEN_MIN) begin
                  next_s.st = mcah_pkg::MCAH_EXEC;
               end
            end else if (i_rx_valid) begin
               next_s.rx_crc = crc_upd(s.rx_crc, i_rx_data);
               if (s.rxn == mcah_pkg::RX_MAX) begin
                  next_s.rx_ovf = 1'b1;
               end else begin
                  next_s.rxb[s.rxn] = i_rx_data;
                  next_s.rxn = s.rxn + 4'h1;
               end
            end
         end

         mcah_pkg::MCAH_EXEC: begin
            next_s.st = mcah_pkg::MCAH_RX;
            next_s.txb = s.txb;
            next_s.txb[0] = s.station;
            next_s.txb[1] = q_fc;
            if (q_fc == mcah_pkg::FC_READ) begin
               if (q_adr >= mcah_pkg::RD_COILS) begin
                  sub = mcah_pkg::SUB_ADDR;
               end else if (q_cnt == 16'h0000 || q_cnt > mcah_pkg::RD_COILS) begin
                  sub = mcah_pkg::SUB_ADDR;
               end else begin
                  // Zeros shift in past coil 80
                  sh = coils >> q_adr[6:0];
                  msk = (80'h1 << q_cnt[6:0]) - 80'h1;
                  sh = sh & msk;
                  nb = (q_cnt + 16'h0007) >> 3;
                  next_s.txb[2] = nb[7:0];
                  for (int j = 0; j < 10; j++) begin
                     next_s.txb[3 + j] = sh[8 * j +: 8];
                  end
                  rlen = 4'h3 + nb[3:0];
               end
            end else if (q_fc == mcah_pkg::FC_WR_ONE) begin
               if (q_adr >= mcah_pkg::WR_COILS) begin
                  sub = mcah_pkg::SUB_ADDR;
               end else if (q_cnt != mcah_pkg::COIL_ON && q_cnt != mcah_pkg::COIL_OFF) begin
                  sub = mcah_pkg::SUB_DATA;
               end else begin
                  wr[q_adr[3:0]] = q_cnt == mcah_pkg::COIL_ON;
                  for (int j = 2; j < 6; j++) begin
                     next_s.txb[j] = s.rxb[j];
                  end
                  rlen = mcah_pkg::LEN_ECHO;
               end
            end else if (q_fc == mcah_pkg::FC_WR_MANY) begin
               if (q_adr >= mcah_pkg::WR_COILS) begin
                  sub = mcah_pkg::SUB_ADDR;
               end else if (q_cnt == 16'h0000 || q_cnt > mcah_pkg::WR_COILS) begin
                  sub = mcah_pkg::SUB_ADDR;
               end else if (q_bc == 8'h00 || q_bc > mcah_pkg::WR_MAX_BC) begin
                  sub = mcah_pkg::SUB_DATA;
               end else if (q_cnt > mcah_pkg::ONE_BYTE_COILS && q_bc < mcah_pkg::WR_MAX_BC) begin
                  sub = mcah_pkg::SUB_DATA;
               end else begin
                  // Coils past 16 dropped silently
                  for (int j = 0; j < 16; j++) begin
                     if (j < q_cnt && q_adr + j < mcah_pkg::WR_COILS) begin
                        wr[q_adr[3:0] + j[3:0]] = q_wdat[j];
                     end
                  end
                  for (int j = 2; j < 6; j++) begin
                     next_s.txb[j] = s.rxb[j];
                  end
                  rlen = mcah_pkg::LEN_ECHO;
               end
            end else begin
               sub = mcah_pkg::SUB_FC;
            end

            if (for_us) begin
               if (sub != 8'h00) begin
                  // Refused query is not executed
                  next_s.txb[1] = q_fc | mcah_pkg::EXC_FLAG;
                  next_s.txb[2] = sub;
                  next_s.last_sub = sub;
                  rlen = mcah_pkg::LEN_ERR;
               end else if (q_fc != mcah_pkg::FC_READ) begin
                  // Reads keep a same-cycle software write
                  next_s.run_cmd = wr & ~mcah_pkg::RSV_RUN;
               end
               next_s.st = mcah_pkg::MCAH_TXB;
               next_s.txlen = rlen;
               next_s.txi = 4'h1;
               next_s.tx_data = s.station;
               next_s.tx_valid = 1'b1;
               next_s.tx_crc = crc_upd(mcah_pkg::CRC_INIT, s.station);
            end
            // Station zero or other station: silent
         end

         mcah_pkg::MCAH_TXB: begin
            if (i_tx_ready) begin
               if (s.txi < s.txlen) begin
                  next_s.tx_data = s.txb[s.txi];
                  next_s.tx_crc = crc_upd(s.tx_crc, s.txb[s.txi]);
                  next_s.txi = s.txi + 4'h1;
               end else begin
                  next_s.tx_data = s.tx_crc[7:0];
                  next_s.st = mcah_pkg::MCAH_TXL;
               end
            end
         end

         mcah_pkg::MCAH_TXL: begin
            if (i_tx_ready) begin
               next_s.tx_data = s.tx_crc[15:8];
               next_s.st = mcah_pkg::MCAH_TXH;
            end
         end

         mcah_pkg::MCAH_TXH: begin
            if (i_tx_ready) begin
               next_s.tx_valid = 1'b0;
               next_s.st = mcah_pkg::MCAH_RX;
            end
         end

         default: begin
            next_s.st = mcah_pkg::MCAH_RX;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s <= '0;
         s.st <= mcah_pkg::MCAH_RX;
         s.rx_crc <= mcah_pkg::CRC_INIT;
         s.station <= mcah_pkg::STATION_RST;
         s.run_cmd <= mcah_pkg::RUN_RST;
      end else begin
         s <= next_s;
      end
   end

   assign o_tx_valid = s.tx_valid;
   assign o_tx_data = s.tx_data;
   assign o_tx_last = s.st == mcah_pkg::MCAH_TXH;
   assign o_run_command_word = s.run_cmd;
   assign o_wb_dat = s.rdat;
   assign o_wb_ack = s.ack;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   bcast_silent_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      bcast |=> s.st == mcah_pkg::MCAH_RX && !s.tx_valid)
      else $error("reply sent to broadcast");

   rd_addr_err_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      for_us && q_fc == mcah_pkg::FC_READ && q_adr >= 16'h0050
      |=> s.txb[1] == 8'h81 && s.txb[2] == 8'h02 && s.txlen == 4'h3)
      else $error("read address error reply wrong");

   rd_cnt_err_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      for_us && q_fc == mcah_pkg::FC_READ && q_adr < 16'h0050 && q_cnt == 16'h0000
      |=> s.txb[2] == 8'h02)
      else $error("read count zero not refused");

   rd_len_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      for_us && q_fc == mcah_pkg::FC_READ && q_adr < 16'h0050 && q_cnt == 16'h0009
      |=> s.txb[2] == 8'h02 && s.txlen == 4'h5 && s.txb[4][7:1] == 7'h00)
      else $error("read byte count or padding wrong");

   wr_one_addr_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      for_us && q_fc == mcah_pkg::FC_WR_ONE && q_adr >= 16'h0010
      |=> s.txb[1] == 8'h85 && $stable(s.run_cmd))
      else $error("single write bad address accepted");

   wr_one_echo_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      for_us && q_fc == mcah_pkg::FC_WR_ONE && q_adr < 16'h0010 && q_cnt == 16'hFF00
      && q_adr != 16'h000B && q_adr != 16'h000C
      |=> s.txlen == 4'h6 && s.run_cmd[$past(q_adr[3:0])] && s.txb[4] == 8'hFF)
      else $error("single write echo or effect wrong");

   rsv_zero_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (s.run_cmd & 16'h1800) == 16'h0000)
      else $error("reserved run coil set");

   wr_bc_err_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      for_us && q_fc == mcah_pkg::FC_WR_MANY && q_adr < 16'h0010 && q_cnt == 16'h0001
      && q_bc == 8'h03 |=> s.txb[1] == 8'h8F && s.txb[2] == 8'h03)
      else $error("byte count three not refused");

   tx_end_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      o_tx_last && i_tx_ready |=> !o_tx_valid ##1 !o_tx_valid)
      else $error("transmit did not stop after check");

   rd_cnt_high_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      for_us && q_fc == mcah_pkg::FC_READ && q_adr < 16'h0050 && q_cnt > 16'h0050
      |=> s.txb[1] == 8'h81 && s.txb[2] == 8'h02 && s.txlen == 4'h3)
      else $error("read count above range not refused");

   rd_run_word_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      for_us && q_fc == mcah_pkg::FC_READ && q_adr == 16'h0000 && q_cnt == 16'h0050
      |=> s.txb[2] == 8'h0A && s.txlen == 4'hD && s.txb[3] == $past(s.run_cmd[7:0])
      && s.txb[4] == $past(s.run_cmd[15:8]))
      else $error("run word not first in read reply");

   wr_one_off_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      for_us && q_fc == mcah_pkg::FC_WR_ONE && q_adr < 16'h0010 && q_cnt == 16'h0000
      |=> s.txlen == 4'h6 && !s.run_cmd[$past(q_adr[3:0])])
      else $error("single write off not applied");

   wr_many_addr_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      for_us && q_fc == mcah_pkg::FC_WR_MANY && q_adr >= 16'h0010
      |=> s.txb[1] == 8'h8F && s.txb[2] == 8'h02 && s.txlen == 4'h3)
      else $error("multiple write bad address accepted");

   wr_many_cnt_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      for_us && q_fc == mcah_pkg::FC_WR_MANY && q_adr < 16'h0010
      && (q_cnt == 16'h0000 || q_cnt > 16'h0010) |=> s.txb[2] == 8'h02 && s.txlen == 4'h3)
      else $error("multiple write bad count accepted");

   wr_pair_err_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      for_us && q_fc == mcah_pkg::FC_WR_MANY && q_adr < 16'h0010 && q_cnt > 16'h0008
      && q_cnt < 16'h0011 && q_bc == 8'h01 |=> s.txb[1] == 8'h8F && s.txb[2] == 8'h03)
      else $error("count and byte count mismatch accepted");

   bcast_no_write_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      bcast && !i_wb_cyc |=> $stable(s.run_cmd))
      else $error("broadcast changed run word");

   exc_func_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      for_us && q_fc == 8'h03 |=> s.txb[1] == 8'h83 && s.txb[2] == 8'h01 && s.txlen == 4'h3)
      else $error("unknown function reply wrong");

endmodule : mcah_coil_handler

// file: hw/mcah_pkg.sv
// Constants and types for the coil access handler
package mcah_pkg;
   localparam logic [7:0] FC_READ = 8'h01;
   localparam logic [7:0] FC_WR_ONE = 8'h05;
   localparam logic [7:0] FC_WR_MANY = 8'h0F;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] SUB_FC = 8'h01;
   localparam logic [7:0] SUB_ADDR = 8'h02;
   localparam logic [7:0] SUB_DATA = 8'h03;
   localparam logic [7:0] BCAST = 8'h00;
   localparam logic [15:0] COIL_ON = 16'hFF00;
   localparam logic [15:0] COIL_OFF = 16'h0000;
   localparam logic [15:0] RD_COILS = 16'h0050;
   localparam logic [15:0] WR_COILS = 16'h0010;
   localparam logic [7:0] WR_MAX_BC = 8'h02;
   localparam logic [15:0] ONE_BYTE_COILS = 16'h0008;
   localparam logic [15:0] RSV_RUN = 16'h1800;
   localparam logic [15:0] RSV_STAT2 = 16'hC000;
   localparam logic [15:0] RSV_FINAL = 16'h1800;
   localparam logic [15:0] RSV_OUT = 16'hFEE0;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam logic [3:0] LEN_ECHO = 4'h6;
   localparam logic [3:0] LEN_ERR = 4'h3;
   localparam logic [3:0] LEN_MIN = 4'h4;
   localparam logic [3:0] RX_MAX = 4'hB;
   localparam logic [7:0] STATION_RST = 8'h01;
   localparam logic [15:0] RUN_RST = 16'h0000;
   localparam logic [3:0] WB_STATION = 4'h0;
   localparam logic [3:0] WB_RUN = 4'h4;
   localparam logic [3:0] WB_SUB = 4'h8;

   typedef enum logic [2:0] {
      MCAH_RX, MCAH_EXEC, MCAH_TXB, MCAH_TXL, MCAH_TXH
   } mcah_state_t;

   typedef struct packed {
      mcah_state_t st;
      logic [10:0][7:0] rxb;
      logic [3:0] rxn;
      logic rx_ovf;
      logic [15:0] rx_crc;
      logic [14:0][7:0] txb;
      logic [3:0] txlen;
      logic [3:0] txi;
      logic [15:0] tx_crc;
      logic [7:0] tx_data;
      logic tx_valid;
      logic [7:0] station;
      logic [15:0] run_cmd;
      logic [7:0] last_sub;
      logic ack;
      logic [31:0] rdat;
   } mcah_regs_t;
endpackage : mcah_pkg

// file: testbench/mcah_coil_handler_tb.sv
// Self-checking bench for the coil access handler
`timescale 1ns/1ps
module mcah_coil_handler_tb;
   localparam logic [7:0] S = 8'h05;
   logic i_mclk = 1'b0;
   logic i_arst_n = 1'b0;
   logic rx_valid, rx_end, tx_ready, tx_valid, tx_last, ack;
   logic [7:0] rx_data, tx_data;
   logic [15:0] stw = 16'hA5C3, st2 = 16'hFFFF, fin = 16'hFFFF, outw = 16'hFFFF;
   logic [15:0] run_e = 16'h0003, run;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [3:0] adr = 4'h0, sel = 4'h0;
   logic [31:0] dat = 32'h0, rdv, wdo;
   logic [7:0] rq[$], eq[$];
   int miscompares = 0, cmp_count = 0;
   initial forever #25 i_mclk = ~i_mclk;
   mcah_coil_handler i_dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_rx_valid(rx_valid),
      .i_rx_data(rx_data), .i_rx_end(rx_end), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
      .o_tx_last(tx_last), .i_tx_ready(tx_ready), .i_run_status_word(stw),
      .i_run_status_word_two(st2), .i_final_run_command_word(fin),
      .i_output_terminal_info_word(outw), .o_run_command_word(run), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat),
      .o_wb_dat(wdo), .o_wb_ack(ack));
   mcah_host_model i_host (.i_mclk(i_mclk), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
      .i_tx_last(tx_last), .o_tx_ready(tx_ready), .o_rx_valid(rx_valid),
      .o_rx_data(rx_data), .o_rx_end(rx_end));
   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : results
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] m);
      int n;
      n = 0;
      @(posedge i_mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= m;
      dat <= d;
      do begin
         @(posedge i_mclk);
         n++;
      end while (ack !== 1'b1 && n < 100);
      rdv = wdo;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 100) miscompares++;
   endtask : wb
   task automatic mk(input logic [7:0] stn, fc, input logic [15:0] w1, w2);
      rq = '{stn, fc, w1[15:8], w1[7:0], w2[15:8], w2[7:0]};
   endtask : mk
   task automatic txn(input logic bad);
      logic [15:0] c;
      int n;
      n = 0;
      i_host.got.delete();
      if (eq.size() > 0) begin
         c = i_host.crc16(eq);
         eq.push_back(c[7:0]);
         eq.push_back(c[15:8]);
      end
      i_host.send(rq, bad);
      while (i_host.got.size() < eq.size() && n < 400) begin
         @(posedge i_mclk);
         n++;
      end
      repeat (20) @(posedge i_mclk);
      check(i_host.got.size(), eq.size(), "reply length");
      foreach (eq[i]) if (i < i_host.got.size()) check(i_host.got[i], {i == eq.size() - 1, eq[i]},
         "reply byte");
      check(run, run_e, "run word");
   endtask : txn
   // Reply image: run word, then status groups with reserved bits cleared
   task automatic rd(input int a, input int n);
      logic [79:0] img;
      img = {outw & ~mcah_pkg::RSV_OUT, fin & ~mcah_pkg::RSV_FINAL,
         st2 & ~mcah_pkg::RSV_STAT2, stw, run_e};
      mk(S, 8'h01, 16'(a), 16'(n));
      eq = '{S, 8'h01, 8'((n + 7) / 8)};
      for (int k = 0; k < (n + 7) / 8 * 8; k++) begin
         if (k % 8 == 0) eq.push_back(8'h00);
         if (k < n && a + k < 80) eq[eq.size() - 1][k % 8] = img[a + k];
      end
      txn(1'b0);
   endtask : rd
   task automatic fail(input logic [7:0] fc, input logic [15:0] w1, w2, input logic [7:0] bc,
      input logic [7:0] sub);
      mk(S, fc, w1, w2);
      if (fc == 8'h0F) rq = {rq, bc, 8'h01, 8'h00};
      eq = '{S, fc | 8'h80, sub};
      txn(1'b0);
   endtask : fail
   task automatic wr(input logic [7:0] fc, input logic [15:0] w1, w2, input logic [7:0] bc,
      input logic [15:0] d, input logic [15:0] nrun);
      mk(S, fc, w1, w2);
      eq = rq[0:5];
      if (fc == 8'h0F) rq = {rq, bc, d[7:0], d[15:8]};
      run_e = nrun;
      txn(1'b0);
   endtask : wr
   task automatic quiet(input logic [7:0] stn, fc, input logic [15:0] w1, w2, input logic bad);
      mk(stn, fc, w1, w2);
      if (fc == 8'h0F) rq = {rq, 8'h01, 8'hFF, 8'hFF};
      eq.delete();
      txn(bad);
   endtask : quiet
   ////////////////////////////////////////////////////////////////////////////////////////
   // Thirty frames of well under five hundred cycles each
   initial begin
      repeat (20000) @(posedge i_mclk);
      miscompares++;
      results();
   end
   initial begin
      repeat (12) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      check(tx_valid, 1'b0, "tx idle after reset");
      check(run, 16'h0000, "run word reset");
      wb(1'b0, 4'h0, 32'h0, 4'hF);
      check(rdv, 32'h1, "station reset");
      wb(1'b1, 4'h0, 32'h5, 4'hF);
      wb(1'b1, 4'h4, 32'hFFFF, 4'hF);
      check(run, 16'hE7FF, "run reserved bits");
      wb(1'b1, 4'h4, 32'h0000, 4'h1);
      check(run, 16'hE700, "run low lane only");
      wb(1'b0, 4'h4, 32'h0, 4'hF);
      check(rdv, 32'hE700, "run word read back");
      wb(1'b1, 4'h4, 32'h0003, 4'hF);
      wb(1'b1, 4'hC, 32'hFF, 4'hF);
      wb(1'b0, 4'hC, 32'h0, 4'hF);
      check(rdv, 32'h0, "unmapped read");
      wb(1'b0, 4'h0, 32'h0, 4'hF);
      check(rdv, 32'h5, "station after unmapped write");
      i_host.slow <= 1'b1;
      rd(0, 80);
      i_host.slow <= 1'b0;
      rd(13, 9);
      rd(75, 10);
      rd(79, 1);
      fail(8'h01, 16'h0050, 16'h0001, 8'h00, 8'h02);
      fail(8'h01, 16'h0000, 16'h0000, 8'h00, 8'h02);
      fail(8'h01, 16'h0000, 16'h0051, 8'h00, 8'h02);
      wb(1'b0, 4'h8, 32'h0, 4'hF);
      check(rdv, 32'h2, "last subcode");
      fail(8'h03, 16'h0000, 16'h0001, 8'h00, 8'h01);
      quiet(8'h00, 8'h01, 16'h0000, 16'h0001, 1'b0);
      quiet(8'h01, 8'h01, 16'h0000, 16'h0001, 1'b0);
      quiet(S, 8'h01, 16'h0000, 16'h0001, 1'b1);
      wr(8'h05, 16'h0002, 16'hFF00, 8'h00, 16'h0000, 16'h0007);
      wr(8'h05, 16'h0000, 16'h0000, 8'h00, 16'h0000, 16'h0006);
      wr(8'h05, 16'h000B, 16'hFF00, 8'h00, 16'h0000, 16'h0006);
      wr(8'h05, 16'h000F, 16'hFF00, 8'h00, 16'h0000, 16'h8006);
      fail(8'h05, 16'h0010, 16'hFF00, 8'h00, 8'h02);
      fail(8'h05, 16'h0001, 16'h1234, 8'h00, 8'h03);
      quiet(8'h00, 8'h05, 16'h0003, 16'hFF00, 1'b0);
      wr(8'h0F, 16'h0002, 16'h0009, 8'h02, 16'hFFFF, 16'h87FE);
      wr(8'h0F, 16'h0000, 16'h0010, 8'h02, 16'h0000, 16'h0000);
      wr(8'h0F, 16'h000E, 16'h0004, 8'h01, 16'h000F, 16'hC000);
      wr(8'h0F, 16'h0000, 16'h0008, 8'h02, 16'hFF5A, 16'hC05A);
      fail(8'h0F, 16'h0010, 16'h0001, 8'h01, 8'h02);
      fail(8'h0F, 16'h0000, 16'h0000, 8'h01, 8'h02);
      fail(8'h0F, 16'h0000, 16'h0011, 8'h02, 8'h02);
      fail(8'h0F, 16'h0000, 16'h0001, 8'h00, 8'h03);
      fail(8'h0F, 16'h0000, 16'h0001, 8'h03, 8'h03);
      fail(8'h0F, 16'h0000, 16'h0009, 8'h01, 8'h03);
      wb(1'b0, 4'h8, 32'h0, 4'hF);
      check(rdv, 32'h3, "last subcode");
      quiet(8'h00, 8'h0F, 16'h0000, 16'h0001, 1'b0);
      // Over-long frame is dropped
      mk(S, 8'h01, 16'h0000, 16'h0001);
      rq = {rq, 8'h00, 8'h00, 8'h00, 8'h00};
      eq.delete();
      txn(1'b0);
      results();
   end
endmodule : mcah_coil_handler_tb

// file: testbench/mcah_host_model.sv
// Modbus host model: sends request frames and collects reply bytes
`timescale 1ns/1ps
module mcah_host_model (
   // Clock
   input wire logic i_mclk,
   // Reply bytes from the handler
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   input wire logic i_tx_last,
   output logic o_tx_ready,
   // Request bytes to the handler
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   output logic o_rx_end
);
   logic [8:0] got[$];
   logic slow = 1'b0;
   logic [1:0] tick = 2'h0;
   initial begin
      o_rx_valid = 1'b0;
      o_rx_data = 8'h00;
      o_rx_end = 1'b0;
   end
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i]) begin
         c ^= {8'h00, q[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
      return c;
   endfunction : crc16
   // Check field low byte first; idle line shows inverted data
   task automatic send(input logic [7:0] q[$], input logic bad);
      logic [15:0] c;
      c = crc16(q) ^ {15'h0000, bad};
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      foreach (q[i]) begin
         @(posedge i_mclk);
         o_rx_valid <= 1'b1;
         o_rx_data <= q[i];
         @(posedge i_mclk);
         o_rx_valid <= 1'b0;
         o_rx_data <= ~q[i];
      end
      @(posedge i_mclk);
      o_rx_end <= 1'b1;
      @(posedge i_mclk);
      o_rx_end <= 1'b0;
   endtask : send
   // Slow mode takes one byte in four cycles
   always @(posedge i_mclk) begin
      tick <= tick + 2'h1;
      o_tx_ready <= !slow || tick == 2'h3;
      if (i_tx_valid && o_tx_ready) begin
         got.push_back({i_tx_last, i_tx_data});
      end
   end
endmodule : mcah_host_model
